// ===== piab_dev.sv
/*
 * piab_dev: bus port of the peripheral interface adapter.
 * assumes: bus inputs synchronous to clk_i; resolved by piab_if.
 */
// Decided for this implementation: the register offsets and the Wishbone slave port.
// Overview of operation
// R1: data drivers off except during reads
// R2: read drives bus when selected and strobed
// R3: selected write accepts data during strobe
// R4: select needs both highs high, low low
// R5: host keeps selects stable over strobe
// R6: host keeps register selects stable over strobe
// R7: register choice uses selects plus access bit
// R8: enable strobe is the only timing reference
// R9: active-low reset clears every register bit
// R10: host waits after reset before access
// R11: interrupt outputs open-drain, active low
// R12: two flags pull each interrupt output
// R13: four enables gate the flags
// R14: data register read clears port flags
// R15: rearm needs deselected strobe after clear
// R16: two 8-bit ports, four control lines
// R17: host software polls control registers
// R18: host qualifies one chip select
// R19: access bit picks data or direction
// R20: bits 0-5 writable, 6-7 read-only flags
// R21: direction bit 1 output, 0 input
// R22: flag sets on active edge when armed
// R23: write data captured at strobe fall
`timescale 1ns/100ps
module piab_dev
   import piab_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   piab_if.dev             bus,
   input  wire logic [7:0] port_a_in_i,
   input  wire logic [7:0] port_b_in_i,
   input  wire logic       port_a_interrupt_input_i,
   input  wire logic       port_b_interrupt_input_i,
   input  wire logic       port_a_control_line_i,
   input  wire logic       port_b_control_line_i,
   output logic [7:0]      port_a_out_o,
   output logic [7:0]      port_a_oe_n_o,
   output logic [7:0]      port_b_out_o,
   output logic [7:0]      port_b_oe_n_o,
   output logic            port_a_control_line_o,
   output logic            port_a_control_line_oe_n_o,
   output logic            port_b_control_line_o,
   output logic            port_b_control_line_oe_n_o
);
   logic [7:0] out_a_ff;
   logic [7:0] out_b_ff;
   logic [7:0] dir_a_ff;
   logic [7:0] dir_b_ff;
   logic [5:0] cra_ff;
   logic [5:0] crb_ff;
   logic [1:0] flg_a_ff;                // [1]=line 1 flag, [0]=line 2 flag
   logic [1:0] flg_b_ff;
   logic [3:0] arm_ff;                  // a1 a2 b1 b2
   logic [3:0] lin_ff;
   logic       e_ff;
   logic [7:0] rd_ff;
   logic       doe_n_ff;
   logic       interrupt_request_port_a_ff;
   logic       interrupt_request_port_b_ff;
   logic       sel;
   logic       e_rise;
   logic       e_fall;
   logic       hard_rst;
   logic       rd_da;
   logic       rd_db;
   logic [3:0] lines;
   logic [3:0] act_edge;
   logic [3:0] inact_edge;
   logic [3:0] pol;
   logic [7:0] rmux;

   function automatic logic [7:0] piab_mix(input logic [7:0] o, input logic [7:0] d,
                                           input logic [7:0] i);
      piab_mix = (o & d) | (i & ~d); // R21
   endfunction : piab_mix

   assign hard_rst = rst_i || !bus.reset_n; // R9
   assign sel = bus.chip_select_high_a && bus.chip_select_high_b && !bus.chip_select_low_n; // R4
   assign e_rise = bus.enable_strobe && !e_ff; // R8
   assign e_fall = !bus.enable_strobe && e_ff;
   assign rd_da = e_fall && sel && bus.read_not_write && bus.register_select == PIAB_RS_DATA_A
                  && cra_ff[PIAB_CR_ACC_BIT];
   assign rd_db = e_fall && sel && bus.read_not_write && bus.register_select == PIAB_RS_DATA_B
                  && crb_ff[PIAB_CR_ACC_BIT];
   assign lines = {port_a_interrupt_input_i, port_a_control_line_i,
                   port_b_interrupt_input_i, port_b_control_line_i};
   assign pol = {cra_ff[PIAB_CR_POL1_BIT], cra_ff[PIAB_CR_POL2_BIT],
                 crb_ff[PIAB_CR_POL1_BIT], crb_ff[PIAB_CR_POL2_BIT]};
   // line 2 only interrupts when configured as input
   assign act_edge   = (lines ^ ~pol) & ~(lin_ff ^ ~pol) & {1'b1, !cra_ff[PIAB_CR_OUT2_BIT],
                                                            1'b1, !crb_ff[PIAB_CR_OUT2_BIT]};
   assign inact_edge = ~(lines ^ ~pol) & (lin_ff ^ ~pol);

   // -------------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------------
   always_comb begin
      case (bus.register_select) // R7 R19
         PIAB_RS_DATA_A: rmux = cra_ff[PIAB_CR_ACC_BIT] ? piab_mix(out_a_ff, dir_a_ff, port_a_in_i)
                                                         : dir_a_ff;
         PIAB_RS_CTRL_A: rmux = {flg_a_ff, cra_ff}; // R17 R20
         PIAB_RS_DATA_B: rmux = crb_ff[PIAB_CR_ACC_BIT] ? piab_mix(out_b_ff, dir_b_ff, port_b_in_i)
                                                         : dir_b_ff;
         PIAB_RS_CTRL_B: rmux = {flg_b_ff, crb_ff};
         default:        rmux = PIAB_REG_RST;
      endcase
   end

   // -------------------------------------------------------------------
   // host writes
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (hard_rst) begin // R9
         out_a_ff <= PIAB_REG_RST;
         out_b_ff <= PIAB_REG_RST;
         dir_a_ff <= PIAB_REG_RST;
         dir_b_ff <= PIAB_REG_RST;
         cra_ff   <= PIAB_CR_RW_RST;
         crb_ff   <= PIAB_CR_RW_RST;
      end else if (e_fall && sel && !bus.read_not_write) begin // R3 R23
         case (bus.register_select)
            PIAB_RS_DATA_A: if (cra_ff[PIAB_CR_ACC_BIT]) out_a_ff <= bus.host_data_bus;
                            else dir_a_ff <= bus.host_data_bus;
            PIAB_RS_CTRL_A: cra_ff <= bus.host_data_bus[5:0]; // R20
            PIAB_RS_DATA_B: if (crb_ff[PIAB_CR_ACC_BIT]) out_b_ff <= bus.host_data_bus;
                            else dir_b_ff <= bus.host_data_bus;
            PIAB_RS_CTRL_B: crb_ff <= bus.host_data_bus[5:0];
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // data bus drive
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (hard_rst) begin
         e_ff     <= 1'b0;
         doe_n_ff <= 1'b1;
         rd_ff    <= PIAB_REG_RST;
      end else begin
         e_ff     <= bus.enable_strobe;
         doe_n_ff <= !(sel && bus.read_not_write && bus.enable_strobe); // R1 R2
         rd_ff    <= rmux;
      end
   end

   // -------------------------------------------------------------------
   // interrupt flags
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (hard_rst) begin
         flg_a_ff <= 2'h0;
         flg_b_ff <= 2'h0;
         arm_ff   <= 4'h0;
         lin_ff   <= lines;
      end else begin
         lin_ff <= lines;
         // deselected strobe conditions the edge sense
         if (e_rise && !sel) arm_ff <= 4'hF; // R15 R22
         if (inact_edge != 4'h0) arm_ff <= arm_ff & ~inact_edge;
         // set wins over a clear in the same cycle
         flg_a_ff <= (flg_a_ff & {2{!rd_da}}) | (act_edge[3:2] & arm_ff[3:2]); // R14 R22
         flg_b_ff <= (flg_b_ff & {2{!rd_db}}) | (act_edge[1:0] & arm_ff[1:0]);
         if (rd_da) arm_ff[3:2] <= 2'h0; // R15
         if (rd_db) arm_ff[1:0] <= 2'h0;
      end
   end

   // -------------------------------------------------------------------
   // interrupt outputs
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (hard_rst) begin
         interrupt_request_port_a_ff <= 1'b0;
         interrupt_request_port_b_ff <= 1'b0;
      end else begin
         interrupt_request_port_a_ff <= (flg_a_ff[1] && cra_ff[PIAB_CR_EN1_BIT]) || // R12 R13
                    (flg_a_ff[0] && cra_ff[PIAB_CR_EN2_BIT] && !cra_ff[PIAB_CR_OUT2_BIT]);
         interrupt_request_port_b_ff <= (flg_b_ff[1] && crb_ff[PIAB_CR_EN1_BIT]) ||
                    (flg_b_ff[0] && crb_ff[PIAB_CR_EN2_BIT] && !crb_ff[PIAB_CR_OUT2_BIT]);
      end
   end

   // R11: only pull low, never drive high
   assign bus.irq_a_out  = 1'b0;
   assign bus.irq_a_oe_n = !interrupt_request_port_a_ff;
   assign bus.irq_b_out  = 1'b0;
   assign bus.irq_b_oe_n = !interrupt_request_port_b_ff;
   assign bus.dev_dout   = rd_ff;
   assign bus.dev_doe_n  = doe_n_ff;
   // R16: per-bit direction on both ports
   assign port_a_out_o  = out_a_ff;
   assign port_a_oe_n_o = ~dir_a_ff;
   assign port_b_out_o  = out_b_ff;
   assign port_b_oe_n_o = ~dir_b_ff;
   // control lines stay inputs; output modes are outside this block
   assign port_a_control_line_o      = 1'b1;
   assign port_a_control_line_oe_n_o = 1'b1;
   assign port_b_control_line_o      = 1'b1;
   assign port_b_control_line_oe_n_o = 1'b1;
endmodule : piab_dev

// ===== piab_pkg.sv
/*
 * piab_pkg: constants shared by the adapter's bus port and the host-side
 * bus sequencer.
 * assumes: both ends run on one 20 MHz clock (clk_i).
 */
package piab_pkg;
   // -------------------------------------------------------------------
   // register select codes
   // -------------------------------------------------------------------
   localparam logic [1:0] PIAB_RS_DATA_A = 2'h0;
   localparam logic [1:0] PIAB_RS_CTRL_A = 2'h1;
   localparam logic [1:0] PIAB_RS_DATA_B = 2'h2;
   localparam logic [1:0] PIAB_RS_CTRL_B = 2'h3;
   // -------------------------------------------------------------------
   // control register fields
   // -------------------------------------------------------------------
   localparam int PIAB_CR_EN1_BIT  = 0;
   localparam int PIAB_CR_POL1_BIT = 1;
   localparam int PIAB_CR_ACC_BIT  = 2;
   localparam int PIAB_CR_EN2_BIT  = 3;
   localparam int PIAB_CR_POL2_BIT = 4;
   localparam int PIAB_CR_OUT2_BIT = 5;
   localparam logic [5:0] PIAB_CR_RW_RST = 6'h00;
   localparam logic [7:0] PIAB_REG_RST   = 8'h00;
   // -------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 50;
   localparam int RST_SETUP_NS     = 1000;
   localparam int RST_SETUP_CYC    = (RST_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int E_HIGH_NS        = 450;
   localparam int E_HIGH_CYC       = (E_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int E_LOW_NS         = 550;
   localparam int E_LOW_CYC        = (E_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_NS         = 160;
   localparam int SETUP_CYC        = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   // -------------------------------------------------------------------
   // wishbone register map of the host sequencer
   // -------------------------------------------------------------------
   localparam logic [3:0] PIAB_WB_CMD  = 4'h0;
   localparam logic [3:0] PIAB_WB_STAT = 4'h4;
   localparam int PIAB_CMD_DATA_LSB = 0;
   localparam int PIAB_CMD_RS_LSB   = 8;
   localparam int PIAB_CMD_RD_BIT   = 10;
   localparam int PIAB_CMD_E_BIT    = 11;

   typedef enum logic [3:0] {
      PIAB_H_WAIT  = 4'b0001,
      PIAB_H_IDLE  = 4'b0010,
      PIAB_H_SETUP = 4'b0100,
      PIAB_H_EHIGH = 4'b1000
   } piab_host_st_t;
endpackage : piab_pkg

// ===== piab_if.sv
/*
 * piab_if: host bus between host sequencer and adapter.
 * assumes: the data bus wire level is resolved here from output enables
 * (enable low = driving); undriven reads as all ones (pull-up).
 */
`timescale 1ns/100ps
interface piab_if;
   logic       enable_strobe;
   logic       read_not_write;
   logic       chip_select_high_a;
   logic       chip_select_high_b;
   logic       chip_select_low_n;
   logic [1:0] register_select;
   logic [7:0] host_dout;
   logic       host_doe_n;
   logic [7:0] dev_dout;
   logic       dev_doe_n;
   logic [7:0] host_data_bus;
   logic       irq_a_out;
   logic       irq_a_oe_n;
   logic       irq_b_out;
   logic       irq_b_oe_n;
   logic       interrupt_request_port_a_n;
   logic       interrupt_request_port_b_n;
   logic       reset_n;

   assign host_data_bus = !dev_doe_n ? dev_dout : (!host_doe_n ? host_dout : 8'hFF);
   assign interrupt_request_port_a_n = (!irq_a_oe_n) ? irq_a_out : 1'b1;
   assign interrupt_request_port_b_n = (!irq_b_oe_n) ? irq_b_out : 1'b1;

   modport host (output enable_strobe, read_not_write, chip_select_high_a, chip_select_high_b,
                 chip_select_low_n, register_select, host_dout, host_doe_n, reset_n,
                 input host_data_bus, interrupt_request_port_a_n, interrupt_request_port_b_n);
   modport dev  (input enable_strobe, read_not_write, chip_select_high_a, chip_select_high_b,
                 chip_select_low_n, register_select, host_data_bus, reset_n,
                 output dev_dout, dev_doe_n, irq_a_out, irq_a_oe_n, irq_b_out, irq_b_oe_n);
endinterface : piab_if

// ===== piab_host.sv
/*
 * piab_host: host-side bus sequencer; wishbone commands become one
 * enable strobe: a read or write of the adapter, or a deselected strobe if bit 11 is set.
 * assumes: classic wishbone master on the same clock; adapter on bus.
 */
`timescale 1ns/100ps
module piab_host
   import piab_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   piab_if.host             bus
);
   piab_host_st_t st_ff;
   logic [4:0]    cnt_ff;
   logic [7:0]    rdata_ff;
   logic [7:0]    wdata_ff;
   logic [1:0]    rs_ff;
   logic          rd_ff;
   logic          busy_ff;
   logic          ack_ff;
   logic [31:0]   dat_ff;
   logic          e_ff;
   logic          cs_ff;
   logic          rstn_ff;
   logic          doe_n_ff;
   logic          go;

   // write to command register while idle starts a cycle
   assign go = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff && wb_adr_i == PIAB_WB_CMD
               && wb_sel_i[1] && st_ff == PIAB_H_IDLE;

   // -------------------------------------------------------------------
   // bus sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff    <= PIAB_H_WAIT;
         cnt_ff   <= CNT_ZERO;
         e_ff     <= 1'b0;
         cs_ff    <= 1'b0;
         rstn_ff  <= 1'b0;
         doe_n_ff <= 1'b1;
         rd_ff    <= 1'b1;
         rs_ff    <= PIAB_RS_DATA_A;
         wdata_ff <= PIAB_REG_RST;
         rdata_ff <= PIAB_REG_RST;
         busy_ff  <= 1'b0;
      end else begin
         rstn_ff <= 1'b1;
         case (st_ff)
            PIAB_H_WAIT: begin
               // R10
               if (cnt_ff == 5'(RST_SETUP_CYC - 1)) begin
                  st_ff  <= PIAB_H_IDLE;
                  cnt_ff <= CNT_ZERO;
               end else begin
                  cnt_ff <= cnt_ff + 5'h01;
               end
            end
            PIAB_H_IDLE: begin
               if (cnt_ff != CNT_ZERO) begin
                  cnt_ff <= cnt_ff - 5'h01;
               end else if (go) begin
                  rd_ff    <= wb_dat_i[PIAB_CMD_RD_BIT];
                  rs_ff    <= wb_dat_i[PIAB_CMD_RS_LSB +: 2];
                  wdata_ff <= wb_dat_i[PIAB_CMD_DATA_LSB +: 8];
                  cs_ff    <= !wb_dat_i[PIAB_CMD_E_BIT];
                  doe_n_ff <= wb_dat_i[PIAB_CMD_RD_BIT];
                  busy_ff  <= 1'b1;
                  cnt_ff   <= 5'(SETUP_CYC - 1);
                  st_ff    <= PIAB_H_SETUP;
               end
            end
            PIAB_H_SETUP: begin
               if (cnt_ff == CNT_ZERO) begin
                  e_ff   <= 1'b1;
                  cnt_ff <= 5'(E_HIGH_CYC - 1);
                  st_ff  <= PIAB_H_EHIGH;
               end else begin
                  cnt_ff <= cnt_ff - 5'h01;
               end
            end
            PIAB_H_EHIGH: begin
               // select, register select and data stay fixed until e falls
               if (cnt_ff == CNT_ZERO) begin // R5 R6
                  e_ff     <= 1'b0;
                  rdata_ff <= bus.host_data_bus;
                  cnt_ff   <= 5'(E_LOW_CYC - 1);
                  busy_ff  <= 1'b0;
                  st_ff    <= PIAB_H_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 5'h01;
               end
            end
            default: st_ff <= PIAB_H_WAIT;
         endcase
         if (st_ff == PIAB_H_IDLE && cnt_ff == CNT_ZERO && !go) begin
            cs_ff    <= 1'b0;
            doe_n_ff <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // wishbone slave
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
         if (wb_adr_i == PIAB_WB_STAT) begin
            dat_ff <= {21'h000000,
                       !bus.interrupt_request_port_b_n, !bus.interrupt_request_port_a_n,
                       busy_ff || st_ff != PIAB_H_IDLE || cnt_ff != CNT_ZERO, rdata_ff};
         end else begin
            dat_ff <= {21'h000000, rd_ff, rs_ff, wdata_ff};
         end
      end
   end

   assign wb_dat_o = dat_ff;
   assign wb_ack_o = ack_ff;
   // R18: cs_ff plays the qualified-address select
   assign bus.enable_strobe       = e_ff;
   assign bus.read_not_write      = rd_ff;
   assign bus.chip_select_high_a  = cs_ff;
   assign bus.chip_select_high_b  = 1'b1;
   assign bus.chip_select_low_n   = 1'b0;
   assign bus.register_select     = rs_ff;
   assign bus.host_dout           = wdata_ff;
   assign bus.host_doe_n          = doe_n_ff;
   assign bus.reset_n             = rstn_ff;
endmodule : piab_host

// ===== piab_chk.sv
/*
 * piab_chk: protocol checker for the host bus between sequencer and adapter.
 * assumes: instantiated in tb beside piab_if; one clock, sync active-high reset.
 */
`timescale 1ns/100ps
module piab_chk
   import piab_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       enable_strobe,
   input wire logic       read_not_write,
   input wire logic       chip_select_high_a,
   input wire logic       chip_select_high_b,
   input wire logic       chip_select_low_n,
   input wire logic [1:0] register_select,
   input wire logic       host_doe_n,
   input wire logic       dev_doe_n,
   input wire logic       irq_a_out,
   input wire logic       irq_a_oe_n,
   input wire logic       irq_b_out,
   input wire logic       irq_b_oe_n,
   input wire logic       reset_n
);
   logic sel_w;
   assign sel_w = chip_select_high_a & chip_select_high_b & ~chip_select_low_n;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // -------------------------------------------------------------------
   // data bus drive
   // -------------------------------------------------------------------
   property p_drive_cause;
      !dev_doe_n |-> $past(enable_strobe) && $past(sel_w) && $past(read_not_write);
   endproperty
   a_drive_cause: assert property (p_drive_cause) else $error("data bus driven outside a selected read");
   property p_drive_on;
      (enable_strobe && sel_w && read_not_write) |=> !dev_doe_n;
   endproperty
   a_drive_on: assert property (p_drive_on) else $error("selected read strobe not driving data bus");
   property p_drive_off;
      $fell(enable_strobe) |=> dev_doe_n;
   endproperty
   a_drive_off: assert property (p_drive_off) else $error("data bus still driven after strobe fall");
   property p_write_drive;
      (enable_strobe && sel_w && !read_not_write) |-> (!host_doe_n && dev_doe_n);
   endproperty
   a_write_drive: assert property (p_write_drive) else $error("write strobe without host data on bus");
   property p_desel_quiet;
      (enable_strobe && !sel_w) |=> dev_doe_n;
   endproperty
   a_desel_quiet: assert property (p_desel_quiet) else $error("deselected device drove data bus");
   // -------------------------------------------------------------------
   // host stability over the strobe
   // -------------------------------------------------------------------
   property p_sel_stable;
      (enable_strobe && $past(enable_strobe)) |-> $stable({chip_select_high_a, chip_select_high_b, chip_select_low_n});
   endproperty
   a_sel_stable: assert property (p_sel_stable) else $error("chip selects moved during strobe");
   property p_rs_stable;
      (enable_strobe && $past(enable_strobe)) |-> $stable({register_select, read_not_write});
   endproperty
   a_rs_stable: assert property (p_rs_stable) else $error("register select moved during strobe");
   // -------------------------------------------------------------------
   // interrupt and reset
   // -------------------------------------------------------------------
   property p_read_clear;
      ($fell(enable_strobe) && $past(sel_w) && $past(read_not_write) && $past(register_select) == PIAB_RS_DATA_A)
         |-> ##[1:3] irq_a_oe_n;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("port a data read left request active");
   property p_reset_quiet;
      !reset_n |=> (dev_doe_n && irq_a_oe_n && irq_b_oe_n);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after adapter reset");
   property p_irq_od;
      (irq_a_oe_n || !irq_a_out) && (irq_b_oe_n || !irq_b_out);
   endproperty
   a_irq_od: assert property (p_irq_od) else $error("interrupt output pulled high");

   c_read: cover property (enable_strobe && sel_w && read_not_write);
   c_desel: cover property (enable_strobe && !sel_w);
   c_irq: cover property (!irq_a_oe_n);
endmodule : piab_chk

// ===== tb.sv
/*
 * tb: self-checking bench for host sequencer and adapter joined by piab_if.
 * assumes: piab_pkg, piab_if, piab_host, piab_dev and piab_chk compiled first.
 */
`timescale 1ns/100ps
module tb
   import piab_pkg::*;
;
   logic        clk_i;
   logic        rst_i;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [3:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_dat;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic [7:0]  pa_in;
   logic [7:0]  pb_in;
   logic        pa_irq_in;
   logic        pb_irq_in;
   logic        pa_ctl_in;
   logic        pb_ctl_in;
   logic [7:0]  pa_out;
   logic [7:0]  pa_oe_n;
   logic [7:0]  pb_out;
   logic [7:0]  pb_oe_n;
   logic [31:0] stat;
   logic [7:0]  rb;
   int          error_cnt;
   int          tests_run;
   int          cyc_cnt;
   // command word and expected read byte per row
   logic [19:0] rows [13] = '{20'h70000, 20'h0F000, 20'h400F0, 20'h1FF00, 20'h5003F, 20'h10700, 20'h0A500,
                              20'h400AC, 20'h2FF00, 20'h30C00, 20'h25A00, 20'h6005A, 20'h7000C};

   piab_if bus_if();
   piab_host u_piab_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
                          .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
                          .wb_ack_o(wb_ack), .bus(bus_if));
   piab_dev u_piab_dev (.clk_i(clk_i), .rst_i(rst_i), .bus(bus_if), .port_a_in_i(pa_in), .port_b_in_i(pb_in),
                        .port_a_interrupt_input_i(pa_irq_in), .port_b_interrupt_input_i(pb_irq_in),
                        .port_a_control_line_i(pa_ctl_in), .port_b_control_line_i(pb_ctl_in),
                        .port_a_out_o(pa_out), .port_a_oe_n_o(pa_oe_n), .port_b_out_o(pb_out),
                        .port_b_oe_n_o(pb_oe_n), .port_a_control_line_o(), .port_a_control_line_oe_n_o(),
                        .port_b_control_line_o(), .port_b_control_line_oe_n_o());
   piab_chk u_piab_chk (.clk_i(clk_i), .rst_i(rst_i), .enable_strobe(bus_if.enable_strobe),
                        .read_not_write(bus_if.read_not_write), .chip_select_high_a(bus_if.chip_select_high_a),
                        .chip_select_high_b(bus_if.chip_select_high_b),
                        .chip_select_low_n(bus_if.chip_select_low_n), .register_select(bus_if.register_select),
                        .host_doe_n(bus_if.host_doe_n), .dev_doe_n(bus_if.dev_doe_n), .irq_a_out(bus_if.irq_a_out),
                        .irq_a_oe_n(bus_if.irq_a_oe_n), .irq_b_out(bus_if.irq_b_out),
                        .irq_b_oe_n(bus_if.irq_b_oe_n), .reset_n(bus_if.reset_n));

   always #25 clk_i = ~clk_i;

   // -------------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------------
   task print_verdict;
      $display("counts: compares=%0d mismatches=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         print_verdict;
      end
   end

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task pin(input logic seen, input logic exp);
      chk({7'h00, seen}, {7'h00, exp});
   endtask : pin

   // classic cycle: hold until ack is sampled, then release
   task wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk_i);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, adr, wd};
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      rd = wb_rdat;
      {wb_cyc, wb_stb} <= 2'b00;
   endtask : wb

   task busy_wait;
      do begin
         wb(1'b0, PIAB_WB_STAT, 32'h0000_0000, stat);
      end while (stat[8] !== 1'b0);
   endtask : busy_wait

   task cmd(input logic [11:0] c);
      logic [31:0] d;
      wb(1'b1, PIAB_WB_CMD, {20'h00000, c}, d);
      busy_wait;
      rb = stat[7:0];
   endtask : cmd

   task wt;
      repeat (8) @(posedge clk_i);
   endtask : wt

   task done(input string name);
      $display("test %s finished, mismatches so far %0d", name, error_cnt);
   endtask : done

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      {clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
      rst_i = 1'b1;
      wb_sel = 4'hF;
      pa_in = 8'h3C;
      pb_in = 8'h00;
      {pa_irq_in, pb_irq_in, pa_ctl_in, pb_ctl_in} = 4'b0011;
      {error_cnt, tests_run, cyc_cnt} = '0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      busy_wait;
      foreach (rows[i]) begin
         cmd(rows[i][19:8]);
         if (rows[i][18]) chk(rb, rows[i][7:0]);
      end
      chk(pa_oe_n, 8'h0F);
      chk(pa_out, 8'hA5);
      chk(pb_oe_n, 8'h00);
      chk(pb_out, 8'h5A);
      done("registers");
      cmd(12'h800);
      pa_irq_in <= 1'b1;
      wt;
      pin(bus_if.interrupt_request_port_a_n, 1'b0);
      busy_wait;
      pin(stat[9], 1'b1);
      cmd(12'h500);
      chk(rb, 8'h87);
      cmd(12'h400);
      pin(bus_if.interrupt_request_port_a_n, 1'b1);
      pa_irq_in <= 1'b0;
      wt;
      pa_irq_in <= 1'b1;
      wt;
      pin(bus_if.interrupt_request_port_a_n, 1'b1);
      pa_irq_in <= 1'b0;
      cmd(12'h800);
      pa_irq_in <= 1'b1;
      wt;
      pin(bus_if.interrupt_request_port_a_n, 1'b0);
      cmd(12'h106);
      pin(bus_if.interrupt_request_port_a_n, 1'b1);
      cmd(12'h107);
      pin(bus_if.interrupt_request_port_a_n, 1'b0);
      cmd(12'h400);
      done("interrupt a");
      cmd(12'h800);
      pb_ctl_in <= 1'b0;
      wt;
      pin(bus_if.interrupt_request_port_b_n, 1'b0);
      busy_wait;
      pin(stat[10], 1'b1);
      cmd(12'h700);
      chk(rb, 8'h4C);
      cmd(12'h600);
      pin(bus_if.interrupt_request_port_b_n, 1'b1);
      done("interrupt b");
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      busy_wait;
      cmd(12'h500);
      chk(rb, 8'h00);
      chk(pa_oe_n, 8'hFF);
      done("reset");
      print_verdict;
   end
endmodule : tb
